//--- logic/io_ports_consts.svh
// register offsets, field positions, reset values and masks for the two-port gpio block
`ifndef IO_PORTS_CONSTS_SVH
`define IO_PORTS_CONSTS_SVH

// register byte offsets on the apb bus
`define OFS_PORT_B_PIN_DATA 12'h000
`define OFS_PORT_B_DIRECTION 12'h004
`define OFS_PORT_B_ANALOG_SELECT 12'h008
`define OFS_PORT_B_CHANGE_ENABLE 12'h00c
`define OFS_PORT_B_PULLUP_ENABLE 12'h010
`define OFS_PORT_C_PIN_DATA 12'h014
`define OFS_PORT_C_DIRECTION 12'h018
`define OFS_PORT_C_ANALOG_SELECT 12'h01c
`define OFS_PORT_CONTROL 12'h020
`define OFS_PERIPH_SELECT 12'h024

// implemented bit mask of port b (bits 7:4)
`define PORT_B_MASK 8'hf0
// analog capable bits of port b (bits 5:4)
`define PORT_B_ANALOG_MASK 8'h30

// control register fields
`define CTRL_PULLUP_DISABLE_BIT 0
`define CTRL_CHANGE_IE_BIT 1
`define CTRL_CHANGE_FLAG_BIT 2

// reset values
`define RST_DIRECTION 8'hff
`define RST_ANALOG_B 8'h30
`define RST_ANALOG_C 8'hff
`define RST_LATCH 8'h00
`define RST_ZERO 8'h00
`define RST_CONTROL 8'h01

`endif

//--- logic/io_ports_pkg.sv
// types shared by the gpio block files
package io_ports_pkg;

	typedef logic [7:0] byte_t; // one port worth of bits

	// apb access phase tracking, one-hot
	typedef enum logic [2:0]
	{
		BUS_IDLE = 3'b001,
		BUS_SETUP = 3'b010,
		BUS_ACCESS = 3'b100
	} bus_state_e;

	// peripheral select per upper pin of port b
	typedef enum logic [1:0]
	{
		FUNC_GPIO = 2'b00,
		FUNC_PERIPH_A = 2'b01,
		FUNC_PERIPH_B = 2'b10
	} pin_func_e;

endpackage

//--- logic/port_pin_cell.sv
// one port worth of pin logic: direction, latch drive, analog masking of reads
`timescale 1ns/1ps
module port_pin_cell
	import io_ports_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic clkEn, // freezes state while low
	input wire logic [7:0] implMask, // implemented bit positions
	input wire logic [7:0] direction, // 1 = input, 0 = output
	input wire logic [7:0] analogSel, // 1 = analog input
	input wire logic [7:0] latchVal, // output latch contents
	input wire logic [7:0] pinIn, // sensed pin levels
	output logic [7:0] pinOut, // registered pad output value
	output logic [7:0] pinOe, // registered pad output enable
	output logic [7:0] digitalRead // analog-masked pin read, combinational
);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// analog pins read zero, unimplemented bits read zero
	assign digitalRead = pinIn & ~analogSel & implMask;

	// ----------------------------------------------------------------
	// drive path
	// ----------------------------------------------------------------
	// direction steers the driver of implemented bits, analog select plays no part
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pinOe <= 8'h00;
			pinOut <= 8'h00;
		end
		else if (clkEn)
		begin
			pinOe <= ~direction & implMask;
			pinOut <= latchVal & implMask;
		end
	end

endmodule

//--- logic/change_detect.sv
// interrupt-on-change compare against the value latched at the last port read
`include "io_ports_consts.svh"
`timescale 1ns/1ps
module change_detect
	import io_ports_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic clkEn, // freezes state while low
	input wire logic [7:0] sampleIn, // current digital read of port b
	input wire logic [7:0] changeEn, // per-pin change enable
	input wire logic [7:0] direction, // only input pins are watched
	input wire logic snapshot, // port b is being read this cycle
	output logic mismatch // a watched pin differs from snapshot
);

	byte_t snap_r; // value seen at the last read

	// ----------------------------------------------------------------
	// snapshot of the port at each read
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			snap_r <= 8'h00;
		else if (clkEn && snapshot)
			snap_r <= sampleIn;
	end

	// watched input pins that moved since the last read
	assign mismatch = |((sampleIn ^ snap_r) & changeEn & direction & `PORT_B_MASK);

endmodule

//--- logic/io_ports_b_and_c.sv
// top of the two-port gpio block with apb register access
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "io_ports_consts.svh"
`timescale 1ns/1ps
module io_ports_b_and_c
	import io_ports_pkg::*;
(
	input wire logic mclk, // core clock, 20 MHz
	input wire logic reset_n, // synchronous reset, active low
	input wire logic clkEn, // freezes all state while low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic [7:0] portBIn, // port b pin levels
	output logic [7:0] portBOut, // port b pad output value
	output logic [7:0] portBOe, // port b pad output enable
	output logic [7:0] portBPullup, // port b weak pull-up enable
	input wire logic [7:0] portCIn, // port c pin levels
	output logic [7:0] portCOut, // port c pad output value
	output logic [7:0] portCOe, // port c pad output enable
	output logic [1:0] analogChanB, // analog converter enables bits 5:4
	input wire logic periphBit4Oe, // spi/i2c data wants to drive bit4
	input wire logic periphBit4Out, // spi/i2c data drive value
	input wire logic periphBit6Oe, // serial port clock drive enable
	input wire logic periphBit6Out, // serial port clock drive value
	input wire logic periphBit7Oe, // transmitter drive enable on bit7
	input wire logic periphBit7Out, // transmitter tx or sync clock value
	output logic [7:0] periphBIn, // digital pin levels to peripherals
	output logic changeIrq // change interrupt, flag and enable
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	byte_t latchB_r; // port b output latch
	byte_t dirB_r; // port b direction
	byte_t anaB_r; // port b analog select
	byte_t port_b_change_enable_r; // port b change enable
	byte_t port_b_pullup_enable_r; // port b pull-up enable
	byte_t latchC_r; // port c output latch
	byte_t dirC_r; // port c direction
	byte_t anaC_r; // port c analog select
	logic pullDis_r; // global pull-up disable
	logic changeIe_r; // change interrupt enable
	logic changeFlag_r; // change interrupt flag
	byte_t funcSel_r; // peripheral select, two bits per upper pin
	bus_state_e busState_r; // apb phase tracker
	bus_state_e busState_nxt; // next phase

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte lane zero write merge honouring the strobe
	function automatic byte_t mergeByte(input byte_t oldVal, input logic [31:0] wd,
		input logic strb);
		mergeByte = strb ? wd[7:0] : oldVal;
	endfunction

	// pick function select of one upper pin
	function automatic pin_func_e funcOf(input byte_t sel, input logic [1:0] idx);
		funcOf = pin_func_e'(sel[{idx, 1'b0} +: 2]);
	endfunction

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire logic setupPhase = psel && !penable; // first cycle of a transfer
	wire logic accessPhase = psel && penable && (busState_r == BUS_SETUP); // after a setup
	wire logic wrStrobe = accessPhase && pwrite && pstrb[0]; // lane 0 write
	wire logic selPortB = paddr == `OFS_PORT_B_PIN_DATA;
	wire logic selDirB = paddr == `OFS_PORT_B_DIRECTION;
	wire logic selAnaB = paddr == `OFS_PORT_B_ANALOG_SELECT;
	wire logic selIocB = paddr == `OFS_PORT_B_CHANGE_ENABLE;
	wire logic selWpuB = paddr == `OFS_PORT_B_PULLUP_ENABLE;
	wire logic selPortC = paddr == `OFS_PORT_C_PIN_DATA;
	wire logic selDirC = paddr == `OFS_PORT_C_DIRECTION;
	wire logic selAnaC = paddr == `OFS_PORT_C_ANALOG_SELECT;
	wire logic selCtrl = paddr == `OFS_PORT_CONTROL;
	wire logic selFunc = paddr == `OFS_PERIPH_SELECT;
	wire logic mapped = selPortB | selDirB | selAnaB | selIocB | selWpuB | selPortC
		| selDirC | selAnaC | selCtrl | selFunc;

	// ----------------------------------------------------------------
	// pin cells and read values
	// ----------------------------------------------------------------
	byte_t readB; // analog-masked port b pins
	byte_t readC; // analog-masked port c pins
	byte_t cellBOut; // gpio drive for port b
	byte_t cellBOe; // gpio enable for port b
	logic changeHit; // a watched pin moved

	port_pin_cell cellB
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.implMask(`PORT_B_MASK),
		.direction(dirB_r),
		.analogSel(anaB_r),
		.latchVal(latchB_r),
		.pinIn(portBIn),
		.pinOut(cellBOut),
		.pinOe(cellBOe),
		.digitalRead(readB)
	);

	port_pin_cell cellC
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.implMask(8'hff),
		.direction(dirC_r),
		.analogSel(anaC_r),
		.latchVal(latchC_r),
		.pinIn(portCIn),
		.pinOut(portCOut),
		.pinOe(portCOe),
		.digitalRead(readC)
	);

	change_detect chg
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.sampleIn(readB),
		.changeEn(port_b_change_enable_r),
		.direction(dirB_r),
		.snapshot(accessPhase && !pwrite && selPortB),
		.mismatch(changeHit)
	);

	// ----------------------------------------------------------------
	// read-modify-write of the port latches
	// ----------------------------------------------------------------
	// the merge takes the sensed pins only when pstrb[0] is low, and no write happens then, so
	// analog outputs read as zero here but the latch loads pwdata[7:0], masked to bits 7:4 on port b, and loses no analog bits
	wire byte_t rmwB = mergeByte(readB, pwdata, pstrb[0]) & `PORT_B_MASK;
	wire byte_t rmwC = mergeByte(readC, pwdata, pstrb[0]);

	// ----------------------------------------------------------------
	// apb phase tracker
	// ----------------------------------------------------------------
	always_comb
	begin
		case (busState_r)
			BUS_IDLE: busState_nxt = setupPhase ? BUS_SETUP : BUS_IDLE;
			BUS_SETUP: busState_nxt = accessPhase ? BUS_ACCESS : BUS_IDLE;
			BUS_ACCESS: busState_nxt = setupPhase ? BUS_SETUP : BUS_IDLE;
			default: busState_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			busState_r <= BUS_IDLE;
		else if (clkEn)
			busState_r <= busState_nxt;
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			latchB_r <= `RST_LATCH;
			dirB_r <= `RST_DIRECTION & `PORT_B_MASK;
			anaB_r <= `RST_ANALOG_B;
			port_b_change_enable_r <= `RST_ZERO;
			port_b_pullup_enable_r <= `RST_ZERO;
			latchC_r <= `RST_LATCH;
			dirC_r <= `RST_DIRECTION;
			anaC_r <= `RST_ANALOG_C;
			funcSel_r <= `RST_ZERO;
		end
		else if (clkEn && wrStrobe)
		begin
			if (selPortB)
				latchB_r <= rmwB;
			if (selDirB)
				dirB_r <= pwdata[7:0] & `PORT_B_MASK;
			if (selAnaB)
				anaB_r <= pwdata[7:0] & `PORT_B_ANALOG_MASK;
			if (selIocB)
				port_b_change_enable_r <= pwdata[7:0] & `PORT_B_MASK;
			if (selWpuB)
				port_b_pullup_enable_r <= pwdata[7:0] & `PORT_B_MASK;
			if (selPortC)
				latchC_r <= rmwC;
			if (selDirC)
				dirC_r <= pwdata[7:0];
			if (selAnaC)
				anaC_r <= pwdata[7:0];
			if (selFunc)
				funcSel_r <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// control bits and change flag
	// ----------------------------------------------------------------
	// a change in the same cycle as a software clear keeps the flag set
	wire logic ctrlWr = wrStrobe && selCtrl;
	wire logic flagKeep = ctrlWr ? pwdata[`CTRL_CHANGE_FLAG_BIT] : changeFlag_r;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pullDis_r <= 1'(`RST_CONTROL >> `CTRL_PULLUP_DISABLE_BIT);
			changeIe_r <= 1'b0;
			changeFlag_r <= 1'b0;
		end
		else if (clkEn)
		begin
			if (ctrlWr)
			begin
				pullDis_r <= pwdata[`CTRL_PULLUP_DISABLE_BIT];
				changeIe_r <= pwdata[`CTRL_CHANGE_IE_BIT];
			end
			changeFlag_r <= changeHit | flagKeep;
		end
	end

	// ----------------------------------------------------------------
	// alternate functions of port b upper pins
	// ----------------------------------------------------------------
	// bit4: gpio, or spi/i2c data; analog via analog select
	wire logic useP4 = funcOf(funcSel_r, 2'd0) != FUNC_GPIO;
	// bit5: gpio or serial receive, input only for the receiver
	wire logic useP5 = funcOf(funcSel_r, 2'd1) != FUNC_GPIO;
	// bit6: gpio or serial port clock
	wire logic useP6 = funcOf(funcSel_r, 2'd2) != FUNC_GPIO;
	// bit7: gpio, async transmit or sync clock
	wire logic useP7 = funcOf(funcSel_r, 2'd3) != FUNC_GPIO;

	byte_t muxOut; // final port b drive value
	byte_t muxOe; // final port b drive enable

	always_comb
	begin
		muxOut = cellBOut;
		muxOe = cellBOe;
		if (useP4)
		begin
			muxOut[4] = periphBit4Out;
			muxOe[4] = periphBit4Oe;
		end
		if (useP5)
		begin
			muxOe[5] = 1'b0;
			muxOut[5] = 1'b0;
		end
		if (useP6)
		begin
			muxOut[6] = periphBit6Out;
			muxOe[6] = periphBit6Oe;
		end
		if (useP7)
		begin
			muxOut[7] = periphBit7Out;
			muxOe[7] = periphBit7Oe;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			portBOut <= 8'h00;
			portBOe <= 8'h00;
			portBPullup <= 8'h00;
			analogChanB <= 2'b00;
			periphBIn <= 8'h00;
			changeIrq <= 1'b0;
		end
		else if (clkEn)
		begin
			portBOut <= muxOut;
			portBOe <= muxOe;
			portBPullup <= port_b_pullup_enable_r & dirB_r & {8{!pullDis_r}} & `PORT_B_MASK;
			analogChanB <= anaB_r[5:4];
			periphBIn <= readB;
			changeIrq <= changeFlag_r & changeIe_r;
		end
	end

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------
	byte_t rdByte; // selected read value
	always_comb
	begin
		case (1'b1)
			selPortB: rdByte = readB;
			selDirB: rdByte = dirB_r;
			selAnaB: rdByte = anaB_r;
			selIocB: rdByte = port_b_change_enable_r;
			selWpuB: rdByte = port_b_pullup_enable_r;
			selPortC: rdByte = readC;
			selDirC: rdByte = dirC_r;
			selAnaC: rdByte = anaC_r;
			selCtrl: rdByte = {5'h00, changeFlag_r, changeIe_r, pullDis_r};
			selFunc: rdByte = funcSel_r;
			default: rdByte = 8'h00;
		endcase
	end

	// answer with no wait state: ready rises in the first access cycle
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clkEn)
		begin
			pready <= setupPhase;
			pslverr <= setupPhase && !mapped;
			prdata <= (setupPhase && !pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
		end
	end

endmodule

//--- verification/io_ports_b_and_c_assertions.sv
// concurrent checks on the ports of the two-port gpio block
`timescale 1ns/1ps
module io_ports_b_and_c_assertions
(
	input wire logic mclk, // core clock
	input wire logic reset_n, // reset, active low
	input wire logic clkEn, // clock enable
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb strobes
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic [7:0] portBOut, // port b drive value
	input wire logic [7:0] portBOe, // port b drive enable
	input wire logic [7:0] portBPullup, // port b pull-ups
	input wire logic [7:0] portCOut, // port c drive value
	input wire logic [7:0] portCOe, // port c drive enable
	input wire logic [7:0] periphBIn // port b levels to peripherals
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// setup cycle of a running bus transfer
	sequence s_setup;
		psel && !penable && clkEn;
	endsequence
	// write to port c data taken at this edge
	sequence s_wr_c;
		psel && penable && pready && pwrite && paddr == 12'h014 && pstrb[0] && clkEn;
	endsequence

	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready && clkEn |=> !pready)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_rdata_upper: assert property (prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_b_low_zero: assert property ((portBOe[3:0] | portBOut[3:0] | portBPullup[3:0]
		| periphBIn[3:0]) == 4'h0)
		else $error("port b low bits active");
	a_reset_tristate: assert property ($rose(reset_n) |-> (portBOe | portCOe) == 8'h00)
		else $error("pins driven after reset");
	a_latch_drive: assert property (s_wr_c ##1 clkEn ##1 clkEn
		|-> (portCOut & portCOe) == ($past(pwdata[7:0], 2) & portCOe))
		else $error("port c latch not driven");
	a_freeze_hold: assert property (!clkEn |=> $stable(portCOut) && $stable(portCOe)
		&& $stable(portBOe))
		else $error("state moved while frozen");
endmodule

bind io_ports_b_and_c io_ports_b_and_c_assertions chk_u
(
	.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .portBOut(portBOut), .portBOe(portBOe),
	.portBPullup(portBPullup), .portCOut(portCOut), .portCOe(portCOe), .periphBIn(periphBIn)
);

//--- verification/pin_pad_model.sv
// pad model: resolves each pin from design drive, outside drive and pull-up
`timescale 1ns/1ps
module pin_pad_model
(
	input wire logic mclk, // core clock
	input wire logic [7:0] drvOe, // design drives
	input wire logic [7:0] drvOut, // design value
	input wire logic [7:0] pullEn, // weak pull-up on
	input wire logic [7:0] extEn, // outside device drives
	input wire logic [7:0] extVal, // outside value
	output logic [7:0] level // resolved pin level
);
	logic [7:0] last_r = 8'h00; // last level, for floating pins

	// a floating pin shows the inverse of the last level, never a stale one
	always_ff @(posedge mclk)
	begin
		last_r <= level;
	end

	// design drive wins, then outside drive, then pull-up
	assign level = (drvOe & drvOut) | (~drvOe & extEn & extVal)
		| (~drvOe & ~extEn & (pullEn | ~last_r));
endmodule

//--- verification/tb.sv
// self-checking bench for the two-port gpio block
`timescale 1ns/1ps
`include "io_ports_consts.svh"
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("ERROR %0t: got %h exp %h", $time, (g), (e)); \
		end \
	end
module tb;
	logic mclk = 1'b0, reset_n = 1'b0, clkEn = 1'b1; // clock, reset, enable
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
	logic [11:0] paddr = 12'h000; // apb address
	logic [31:0] pwdata = 32'h0, prdata, rd; // apb data, last read
	logic [3:0] pstrb = 4'h0; // apb strobes
	logic pready, pslverr, changeIrq, err, g; // answers, irq, model flag
	logic [7:0] portBIn, portBOut, portBOe, portBPullup, periphBIn, portCIn, portCOut, portCOe;
	logic [1:0] analogChanB; // analog enables
	logic p4o = 1'b0, p4v = 1'b0, p6o = 1'b0, p6v = 1'b0, p7o = 1'b0, p7v = 1'b0; // peripherals
	logic [7:0] extBEn = 8'h00, extBVal = 8'h00, extCEn = 8'h00, extCVal = 8'h00; // outside
	logic [7:0] dB, dC, aB, aC, lB, lC, pB, x; // register model
	logic [7:0] rv [11] = '{0, 8'hf0, 8'h30, 0, 0, 0, 8'hff, 8'hff, 8'h01, 0, 0}; // reset table
	int fail_count = 0, checks_done = 0, i, seed = 32'h3e73d0f8; // counters, seed

	always #25 mclk = ~mclk;

	io_ports_b_and_c dut_u
	(
		.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .portBIn(portBIn), .portBOut(portBOut),
		.portBOe(portBOe), .portBPullup(portBPullup), .portCIn(portCIn), .portCOut(portCOut),
		.portCOe(portCOe), .analogChanB(analogChanB), .periphBit4Oe(p4o), .periphBit4Out(p4v),
		.periphBit6Oe(p6o), .periphBit6Out(p6v), .periphBit7Oe(p7o), .periphBit7Out(p7v),
		.periphBIn(periphBIn), .changeIrq(changeIrq)
	);
	pin_pad_model padB_u
	(
		.mclk(mclk), .drvOe(portBOe), .drvOut(portBOut), .pullEn(portBPullup),
		.extEn(extBEn), .extVal(extBVal), .level(portBIn)
	);
	pin_pad_model padC_u
	(
		.mclk(mclk), .drvOe(portCOe), .drvOut(portCOut), .pullEn(8'h00),
		.extEn(extCEn), .extVal(extCVal), .level(portCIn)
	);

	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic logic [7:0] rnd();
		int v;
		v = $random(seed);
		return v[7:0];
	endfunction

	// expected pin level: latch where driven, outside value where input
	function automatic logic [7:0] lvl(input logic [7:0] d, input logic [7:0] l,
		input logic [7:0] e);
		return (~d & l) | (d & e);
	endfunction

	// one apb transfer: setup, access held until ready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s = 4'h1);
		int n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		// values read right after the edge are the ones the edge sampled
		@(posedge mclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				fail_count++;
				$display("ERROR %0t: no bus answer", $time);
				finish_test();
			end
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// registered outputs follow one cycle after the write edge, port b drive value and enable two cycles
	// checks read the values settled before the third edge; stimulus stays on rising edges
	task automatic settle();
		repeat (3) @(posedge mclk);
	endtask

	// hang guard
	initial
	begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		$display("ERROR %0t: run too long", $time);
		finish_test();
	end

	initial
	begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		settle();
		`CHK(portBOe | portCOe, 8'h00)
		// reset values, and one unmapped word at the end
		for (i = 1; i < 11; i++)
		begin
			if (i != 5)
			begin
				apb(1'b0, 12'(4 * i), 8'h00);
				`CHK(rd, {24'h0, rv[i]})
				`CHK(err, 1'(i == 10))
			end
		end
		// port c: random direction, latch, analog and outside levels
		for (i = 0; i < 8; i++)
		begin
			aC = rnd();
			dC = rnd() | aC;
			lC = rnd();
			extCEn <= dC;
			extCVal <= rnd();
			apb(1'b1, `OFS_PORT_C_ANALOG_SELECT, aC);
			apb(1'b1, `OFS_PORT_C_DIRECTION, dC);
			apb(1'b1, `OFS_PORT_C_PIN_DATA, lC);
			settle();
			`CHK(portCOe, ~dC)
			`CHK(portCOut & ~dC, lC & ~dC)
			apb(1'b0, `OFS_PORT_C_PIN_DATA, 8'h00);
			`CHK(rd, {24'h0, lvl(dC, lC, extCVal) & ~aC})
		end
		// analog outputs keep driving, read zero, and lose latch bits on merge
		extCEn <= 8'h00;
		apb(1'b1, `OFS_PORT_C_DIRECTION, 8'h00);
		apb(1'b1, `OFS_PORT_C_ANALOG_SELECT, 8'hff);
		apb(1'b1, `OFS_PORT_C_PIN_DATA, 8'h01);
		settle();
		`CHK(portCOe, 8'hff)
		`CHK(portCOut, 8'h01)
		apb(1'b0, `OFS_PORT_C_PIN_DATA, 8'h00);
		`CHK(rd, 32'h0)
		apb(1'b1, `OFS_PORT_C_PIN_DATA, rd[7:0] | 8'h80);
		apb(1'b1, `OFS_PORT_C_PIN_DATA, 8'h3c, 4'h0);
		settle();
		`CHK(portCOut, 8'h80)
		// port b: upper pins, analog masking, pull-ups
		for (i = 0; i < 8; i++)
		begin
			dB = rnd();
			aB = rnd();
			lB = rnd();
			pB = rnd();
			x = rnd();
			g = x[0];
			extBEn <= dB;
			extBVal <= rnd();
			apb(1'b1, `OFS_PORT_B_ANALOG_SELECT, aB);
			apb(1'b1, `OFS_PORT_B_DIRECTION, dB);
			apb(1'b1, `OFS_PORT_B_PIN_DATA, lB);
			apb(1'b1, `OFS_PORT_B_PULLUP_ENABLE, pB);
			apb(1'b1, `OFS_PORT_CONTROL, {7'h0, g});
			settle();
			aB = aB & 8'h30;
			x = lvl(dB, lB, extBVal) & ~aB & 8'hf0;
			`CHK(portBOe, ~dB & 8'hf0)
			`CHK(portBOut & ~dB & 8'hf0, lB & ~dB & 8'hf0)
			`CHK(portBPullup, pB & dB & 8'hf0 & {8{~g}})
			`CHK(analogChanB, aB[5:4])
			`CHK(periphBIn, x)
			apb(1'b0, `OFS_PORT_B_PIN_DATA, 8'h00);
			`CHK(rd, {24'h0, x})
		end
		// change detection on watched input pins
		apb(1'b1, `OFS_PORT_B_ANALOG_SELECT, 8'h00);
		apb(1'b1, `OFS_PORT_B_DIRECTION, 8'hf0);
		extBEn <= 8'hf0;
		extBVal <= 8'ha0;
		apb(1'b1, `OFS_PORT_B_CHANGE_ENABLE, 8'hf0);
		apb(1'b0, `OFS_PORT_B_PIN_DATA, 8'h00);
		apb(1'b1, `OFS_PORT_CONTROL, 8'h02);
		settle();
		`CHK(changeIrq, 1'b0)
		extBVal <= 8'h60;
		settle();
		`CHK(changeIrq, 1'b1)
		apb(1'b0, `OFS_PORT_B_PIN_DATA, 8'h00);
		apb(1'b1, `OFS_PORT_B_CHANGE_ENABLE, 8'h10);
		apb(1'b1, `OFS_PORT_CONTROL, 8'h02);
		extBVal <= 8'he0;
		settle();
		`CHK(changeIrq, 1'b0)
		extBVal <= 8'hf0;
		apb(1'b1, `OFS_PORT_CONTROL, 8'h00);
		settle();
		`CHK(changeIrq, 1'b0)
		apb(1'b0, `OFS_PORT_CONTROL, 8'h00);
		`CHK(rd, 32'h4)
		// peripheral ownership of the upper pins, both function codes
		apb(1'b1, `OFS_PORT_B_DIRECTION, 8'h20);
		apb(1'b1, `OFS_PORT_B_PIN_DATA, 8'h00);
		extBEn <= 8'h20;
		extBVal <= 8'h20;
		{p4o, p4v, p6o, p6v, p7o, p7v} <= 6'b111011;
		for (i = 1; i < 3; i++)
		begin
			apb(1'b1, `OFS_PERIPH_SELECT, (i == 1) ? 8'h55 : 8'haa);
			settle();
			`CHK(portBOe, 8'hd0)
			`CHK(portBOut & 8'hd0, 8'h90)
			`CHK(periphBIn, 8'hb0)
		end
		apb(1'b1, `OFS_PERIPH_SELECT, 8'h00);
		settle();
		`CHK(portBOut & 8'hd0, 8'h00)
		// freeze, then a second reset in mid-run
		clkEn <= 1'b0;
		repeat (3) @(posedge mclk);
		clkEn <= 1'b1;
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		settle();
		`CHK(portCOe | portBOe | portBPullup, 8'h00)
		finish_test();
	end
endmodule
